// ==== design/mmd_pkg.sv ====
// Package for the data-space address decoder
package mmd_pkg;
    // ----------------------------------------
    // Address map
    // ----------------------------------------
    localparam int ADDR_W = 14;
    localparam logic [13:0] FAST_RAM_LO = 14'h0000;
    localparam logic [13:0] FAST_RAM_HI = 14'h000e;
    localparam logic [13:0] INDIRECT_ADDR = 14'h000e;
    localparam logic [13:0] INDEX_ADDR = 14'h000f;
    localparam logic [13:0] PERIPH_A_LO = 14'h0010;
    localparam logic [13:0] PERIPH_A_HI = 14'h001e;
    localparam logic [13:0] PAGE_SEL_ADDR = 14'h001f;
    localparam logic [13:0] RAM2_LO = 14'h0020;
    localparam logic [13:0] RAM2_HI = 14'h004f;
    localparam logic [13:0] WINDOW_LO = 14'h00c0;
    localparam logic [13:0] WINDOW_HI = 14'h00ff;
    localparam logic [13:0] PERIPH_B_LO = 14'h0200;
    localparam logic [13:0] PERIPH_B_HI = 14'h023f;
    localparam logic [13:0] NVM_LO = 14'h3800;
    localparam logic [13:0] NVM_HI = 14'h3fff;
    localparam logic [13:0] PAGE0_HI = 14'h00ff;
    // Tiny form reaches 0x00-0x0f, short form 0x00-0x1f
    localparam int TINY_W = 4;
    localparam int SHORT_W = 5;
    localparam int WIN_OFS_W = 6;
    localparam logic [7:0] INDEX_RST = 8'h00;
    localparam logic [7:0] PAGE_SEL_RST = 8'h00;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {
        MMD_FORM_FULL,
        MMD_FORM_TINY,
        MMD_FORM_SHORT
    } mmd_form_t;

    typedef enum logic [2:0] {
        MMD_TGT_NONE,
        MMD_TGT_RAM,
        MMD_TGT_INDEX,
        MMD_TGT_PERIPH_A,
        MMD_TGT_PAGE_SEL,
        MMD_TGT_PERIPH_B,
        MMD_TGT_NVM
    } mmd_tgt_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic fetch;
        mmd_form_t form;
        logic [13:0] addr;
        logic [7:0] opcode;
        logic [7:0] wdata;
    } mmd_req_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [13:0] addr;
        logic [7:0] wdata;
    } mmd_mem_t;
endpackage

// ==== design/mmd_decoder.sv ====
// Data-space address decoder with indirect port and paging window
`timescale 1ns/1ns

// Operation
// - Fast RAM answers at 0x0000-0x000E and general RAM at 0x0020-0x004F.
// - The frequent peripheral group is decoded at 0x0010-0x001E.
// - Any access to an unimplemented address raises a reset request.
// - Address 0x000E is the indirect port, redirected to the index pointer's target.
// - The index pointer is read and written directly at 0x000F.
// - The 8-bit index pointer supplies the address of every indirect access.
// - Reset clears the index pointer to zero.
// - The indirect port reaches 0x0000-0x00BF; index values 0xC0-0xFF go through the paging window.
// - Index 0x0E through the indirect port reaches the RAM byte at 0x000E.
// - Index 0x0F through the indirect port reads or writes the index pointer itself.
// - Tiny-form accesses take their address from the low opcode bits.
// - Short-form accesses take their address from the low opcode bits.
// - With page select 0x00, window byte 0x00CE reaches the RAM byte at 0x000E.
module mmd_decoder (
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    input wire mmd_pkg::mmd_req_t CPU_REQ,
    output logic [7:0] CPU_RDATA,
    output logic CPU_ACK,
    output logic RESET_REQ,
    output mmd_pkg::mmd_mem_t RAM_REQ,
    input wire logic [7:0] RAM_RDATA,
    output mmd_pkg::mmd_mem_t PERIPH_A_REQ,
    input wire logic [7:0] PERIPH_A_RDATA,
    output mmd_pkg::mmd_mem_t PERIPH_B_REQ,
    input wire logic [7:0] PERIPH_B_RDATA,
    output mmd_pkg::mmd_mem_t NVM_REQ,
    input wire logic [7:0] NVM_RDATA,
    output logic [7:0] INDEX_PTR,
    output logic [7:0] PAGE_SELECT
);
    // ----------------------------------------
    // Address formation
    // ----------------------------------------
    logic [7:0] index_q;
    logic [7:0] page_sel_q;
    logic [13:0] cpu_addr;
    logic [13:0] eff_addr;
    mmd_pkg::mmd_tgt_t tgt;
    logic is_ram;

    always_comb begin
        case (CPU_REQ.form)
            mmd_pkg::MMD_FORM_TINY: begin
                cpu_addr = {{(mmd_pkg::ADDR_W - mmd_pkg::TINY_W){1'b0}},
                            CPU_REQ.opcode[mmd_pkg::TINY_W-1:0]};
            end
            mmd_pkg::MMD_FORM_SHORT: begin
                cpu_addr = {{(mmd_pkg::ADDR_W - mmd_pkg::SHORT_W){1'b0}},
                            CPU_REQ.opcode[mmd_pkg::SHORT_W-1:0]};
            end
            default: begin
                cpu_addr = CPU_REQ.addr;
            end
        endcase
    end

    always_comb begin
        eff_addr = cpu_addr;
        if (cpu_addr == mmd_pkg::INDIRECT_ADDR) begin
            eff_addr = {6'h00, index_q};
        end
        if (eff_addr >= mmd_pkg::WINDOW_LO && eff_addr <= mmd_pkg::WINDOW_HI) begin
            eff_addr = {page_sel_q, eff_addr[mmd_pkg::WIN_OFS_W-1:0]};
        end
    end

    // ----------------------------------------
    // Target decode
    // ----------------------------------------
    always_comb begin
        tgt = mmd_pkg::MMD_TGT_NONE;
        if (eff_addr <= mmd_pkg::FAST_RAM_HI) begin
            tgt = mmd_pkg::MMD_TGT_RAM;
        end else if (eff_addr == mmd_pkg::INDEX_ADDR) begin
            tgt = mmd_pkg::MMD_TGT_INDEX;
        end else if (eff_addr >= mmd_pkg::PERIPH_A_LO && eff_addr <= mmd_pkg::PERIPH_A_HI) begin
            tgt = mmd_pkg::MMD_TGT_PERIPH_A;
        end else if (eff_addr == mmd_pkg::PAGE_SEL_ADDR) begin
            tgt = mmd_pkg::MMD_TGT_PAGE_SEL;
        end else if (eff_addr >= mmd_pkg::RAM2_LO && eff_addr <= mmd_pkg::RAM2_HI) begin
            tgt = mmd_pkg::MMD_TGT_RAM;
        end else if (eff_addr >= mmd_pkg::PERIPH_B_LO && eff_addr <= mmd_pkg::PERIPH_B_HI) begin
            tgt = mmd_pkg::MMD_TGT_PERIPH_B;
        end else if (eff_addr >= mmd_pkg::NVM_LO) begin
            tgt = mmd_pkg::MMD_TGT_NVM;
        end
    end

    assign is_ram = (tgt == mmd_pkg::MMD_TGT_RAM);

    // ----------------------------------------
    // Downstream strobes
    // ----------------------------------------
    always_comb begin
        RAM_REQ = '{valid: CPU_REQ.valid && is_ram, write: CPU_REQ.write,
                    addr: eff_addr, wdata: CPU_REQ.wdata};
        PERIPH_A_REQ = '{valid: CPU_REQ.valid && tgt == mmd_pkg::MMD_TGT_PERIPH_A,
                         write: CPU_REQ.write, addr: eff_addr, wdata: CPU_REQ.wdata};
        PERIPH_B_REQ = '{valid: CPU_REQ.valid && tgt == mmd_pkg::MMD_TGT_PERIPH_B,
                         write: CPU_REQ.write, addr: eff_addr, wdata: CPU_REQ.wdata};
        NVM_REQ = '{valid: CPU_REQ.valid && tgt == mmd_pkg::MMD_TGT_NVM,
                    write: CPU_REQ.write, addr: eff_addr, wdata: CPU_REQ.wdata};
    end

    // ----------------------------------------
    // Local registers
    // ----------------------------------------
    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            index_q <= mmd_pkg::INDEX_RST;
        end else if (CPU_REQ.valid && CPU_REQ.write && tgt == mmd_pkg::MMD_TGT_INDEX) begin
            index_q <= CPU_REQ.wdata;
        end
    end

    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            page_sel_q <= mmd_pkg::PAGE_SEL_RST;
        end else if (CPU_REQ.valid && CPU_REQ.write && tgt == mmd_pkg::MMD_TGT_PAGE_SEL) begin
            page_sel_q <= CPU_REQ.wdata;
        end
    end

    // ----------------------------------------
    // Answer to the core
    // ----------------------------------------
    logic [7:0] rdata_d;
    mmd_pkg::mmd_tgt_t tgt_q;
    logic rd_q;

    always_comb begin
        case (tgt)
            mmd_pkg::MMD_TGT_RAM: rdata_d = RAM_RDATA;
            mmd_pkg::MMD_TGT_INDEX: rdata_d = index_q;
            mmd_pkg::MMD_TGT_PERIPH_A: rdata_d = PERIPH_A_RDATA;
            mmd_pkg::MMD_TGT_PAGE_SEL: rdata_d = page_sel_q;
            mmd_pkg::MMD_TGT_PERIPH_B: rdata_d = PERIPH_B_RDATA;
            mmd_pkg::MMD_TGT_NVM: rdata_d = NVM_RDATA;
            default: rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            CPU_RDATA <= 8'h00;
            CPU_ACK <= 1'b0;
            RESET_REQ <= 1'b0;
            tgt_q <= mmd_pkg::MMD_TGT_NONE;
            rd_q <= 1'b0;
        end else begin
            CPU_RDATA <= (CPU_REQ.valid && !CPU_REQ.write) ? rdata_d : CPU_RDATA;
            CPU_ACK <= CPU_REQ.valid && tgt != mmd_pkg::MMD_TGT_NONE;
            RESET_REQ <= CPU_REQ.valid && tgt == mmd_pkg::MMD_TGT_NONE;
            tgt_q <= tgt;
            rd_q <= CPU_REQ.valid && !CPU_REQ.write;
        end
    end

    assign INDEX_PTR = index_q;
    assign PAGE_SELECT = page_sel_q;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST);

    unmapped_reset_a: assert property (
        CPU_REQ.valid && tgt == mmd_pkg::MMD_TGT_NONE |=> RESET_REQ && !CPU_ACK)
        else $error("unmapped access without reset");
    gap_unmapped_a: assert property (
        CPU_REQ.valid && CPU_REQ.form == mmd_pkg::MMD_FORM_FULL
        && CPU_REQ.addr == 14'h0050 |=> RESET_REQ) else $error("gap not unmapped");
    indirect_route_a: assert property (
        CPU_REQ.valid && cpu_addr == mmd_pkg::INDIRECT_ADDR
        && index_q < mmd_pkg::WINDOW_LO[7:0] |-> eff_addr == {6'h00, index_q})
        else $error("indirect address wrong");
    indirect_ram_a: assert property (
        CPU_REQ.valid && cpu_addr == mmd_pkg::INDIRECT_ADDR
        && index_q == 8'h0e |-> RAM_REQ.valid && RAM_REQ.addr == 14'h000e)
        else $error("index 0e misses ram");
    self_write_a: assert property (
        CPU_REQ.valid && CPU_REQ.write
        && cpu_addr == mmd_pkg::INDIRECT_ADDR && index_q == 8'h0f
        |=> index_q == $past(CPU_REQ.wdata)) else $error("index self write lost");
    self_read_a: assert property (
        CPU_REQ.valid && !CPU_REQ.write
        && cpu_addr == mmd_pkg::INDEX_ADDR |=> CPU_RDATA == $past(index_q))
        else $error("index read wrong");
    window_map_a: assert property (
        CPU_REQ.valid && CPU_REQ.form == mmd_pkg::MMD_FORM_FULL
        && CPU_REQ.addr == 14'h00ce && page_sel_q == 8'h00 |-> RAM_REQ.valid
        && RAM_REQ.addr == 14'h000e) else $error("window 00ce miss");
    tiny_addr_a: assert property (
        CPU_REQ.form == mmd_pkg::MMD_FORM_TINY
        |-> cpu_addr == {10'h000, CPU_REQ.opcode[3:0]}) else $error("tiny decode");
    short_periph_a: assert property (
        CPU_REQ.valid && CPU_REQ.form == mmd_pkg::MMD_FORM_SHORT
        && CPU_REQ.opcode[4:0] == 5'h13 |-> PERIPH_A_REQ.valid)
        else $error("short decode");
    page_write_a: assert property (
        CPU_REQ.valid && CPU_REQ.write
        && tgt == mmd_pkg::MMD_TGT_PAGE_SEL |=> PAGE_SELECT == $past(CPU_REQ.wdata))
        else $error("page select write lost");
    index_clear_a: assert property (
        $fell(SYS_RST) |-> index_q == mmd_pkg::INDEX_RST)
        else $error("index not cleared by reset");
    mapped_ack_a: assert property (
        CPU_REQ.valid && tgt != mmd_pkg::MMD_TGT_NONE |=> CPU_ACK && !RESET_REQ)
        else $error("mapped access not acknowledged");
    ram2_map_a: assert property (
        CPU_REQ.valid && CPU_REQ.form == mmd_pkg::MMD_FORM_FULL
        && CPU_REQ.addr >= mmd_pkg::RAM2_LO && CPU_REQ.addr <= mmd_pkg::RAM2_HI
        |-> RAM_REQ.valid && RAM_REQ.addr == CPU_REQ.addr)
        else $error("general ram not reached");
    periph_b_map_a: assert property (
        CPU_REQ.valid && CPU_REQ.form == mmd_pkg::MMD_FORM_FULL
        && CPU_REQ.addr >= mmd_pkg::PERIPH_B_LO && CPU_REQ.addr <= mmd_pkg::PERIPH_B_HI
        |-> PERIPH_B_REQ.valid && PERIPH_B_REQ.addr == CPU_REQ.addr)
        else $error("peripheral group b not reached");
    one_strobe_a: assert property (
        $onehot0({RAM_REQ.valid, PERIPH_A_REQ.valid, PERIPH_B_REQ.valid, NVM_REQ.valid}))
        else $error("more than one target strobed");

    indirect_c: cover property (CPU_REQ.valid && cpu_addr == mmd_pkg::INDIRECT_ADDR);
    window_c: cover property (CPU_REQ.valid && cpu_addr >= mmd_pkg::WINDOW_LO
        && cpu_addr <= mmd_pkg::WINDOW_HI && !RAM_REQ.valid);
    reset_c: cover property (RESET_REQ);
    rd_periph_b_c: cover property (rd_q && tgt_q == mmd_pkg::MMD_TGT_PERIPH_B);
endmodule

// ==== tb/mmd_targets.sv ====
// Target-side model: RAM, peripheral groups and NVM answering by address
`timescale 1ns/1ns
module mmd_targets (
    input wire mmd_pkg::mmd_mem_t ram_req,
    input wire mmd_pkg::mmd_mem_t pa_req,
    input wire mmd_pkg::mmd_mem_t pb_req,
    input wire mmd_pkg::mmd_mem_t nvm_req,
    output logic [7:0] ram_rdata,
    output logic [7:0] pa_rdata,
    output logic [7:0] pb_rdata,
    output logic [7:0] nvm_rdata
);
    // Unselected targets show the inverted pattern
    function automatic logic [7:0] pat(mmd_pkg::mmd_mem_t r, logic [7:0] salt);
        logic [7:0] v;
        v = r.addr[7:0] ^ {2'h0, r.addr[13:8]} ^ salt;
        return r.valid ? v : ~v;
    endfunction
    assign ram_rdata = pat(ram_req, 8'h11);
    assign pa_rdata = pat(pa_req, 8'h33);
    assign pb_rdata = pat(pb_req, 8'h55);
    assign nvm_rdata = pat(nvm_req, 8'h66);
endmodule

// ==== tb/test_memory_map_indirect_decode.sv ====
// Testbench for the data-space address decoder
`timescale 1ns/1ns
module test_memory_map_indirect_decode;
    logic clk = 1'b0;
    logic rst = 1'b1;
    mmd_pkg::mmd_req_t req = '0;
    mmd_pkg::mmd_mem_t ram_req, pa_req, pb_req, nvm_req;
    logic [7:0] rdata, ram_rd, pa_rd, pb_rd, nvm_rd, idx, pg, m_idx, m_pg, wd;
    logic ack, rreq;
    logic [31:0] r;
    int fails = 0;
    int check_count = 0;
    // Form<<28 | write<<24 | addr<<8 | data
    int tab[] = '{32'h0000_0000, 32'h0000_0d00, 32'h0000_1000, 32'h0000_1e00, 32'h0000_2000,
        32'h0000_4f00, 32'h0000_5000, 32'h0000_bf00, 32'h0001_0000, 32'h0001_ff00,
        32'h0002_0000, 32'h0002_3f00, 32'h0002_4000, 32'h0037_ff00, 32'h0038_0000,
        32'h003f_ff00, 32'h0100_0f0e, 32'h0000_0e00, 32'h0100_0e77, 32'h0000_0e00,
        32'h0100_0f0f, 32'h0000_0e00, 32'h0100_0e5a, 32'h0000_0e00, 32'h0100_1f00,
        32'h0000_ce00, 32'h0100_0fce, 32'h0000_0e00, 32'h0100_1fe0, 32'h0000_c500,
        32'h1000_0f00, 32'h1000_0e00, 32'h2000_1f00, 32'h2100_1300, 32'h2000_0100};

    always #4 clk = ~clk;

    mmd_decoder u_dut (.CORE_CLK(clk), .SYS_RST(rst), .CPU_REQ(req), .CPU_RDATA(rdata),
        .CPU_ACK(ack), .RESET_REQ(rreq), .RAM_REQ(ram_req), .RAM_RDATA(ram_rd),
        .PERIPH_A_REQ(pa_req), .PERIPH_A_RDATA(pa_rd), .PERIPH_B_REQ(pb_req),
        .PERIPH_B_RDATA(pb_rd), .NVM_REQ(nvm_req), .NVM_RDATA(nvm_rd), .INDEX_PTR(idx),
        .PAGE_SELECT(pg));
    mmd_targets u_tgt (.ram_req(ram_req), .pa_req(pa_req), .pb_req(pb_req),
        .nvm_req(nvm_req), .ram_rdata(ram_rd), .pa_rdata(pa_rd), .pb_rdata(pb_rd),
        .nvm_rdata(nvm_rd));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Reference: indirect first, then window, then target class
    function automatic int tgt(int e);
        if (e <= 14 || (e >= 'h20 && e <= 'h4f)) return 1;
        if (e == 15) return 2;
        if (e <= 'h1e) return 3;
        if (e == 'h1f) return 4;
        if (e >= 'h200 && e <= 'h23f) return 5;
        if (e >= 'h3800 && e <= 'h3fff) return 6;
        return 0;
    endfunction

    // Issue one access at a falling edge, check strobes now and answer one cycle on
    task automatic acc(input int form, input int a, input logic wr, input logic [7:0] d);
        int e, t;
        logic [7:0] op, exp;
        mmd_pkg::mmd_mem_t sel;
        r = $urandom;
        a = form == 1 ? a % 16 : form == 2 ? a % 32 : a;
        op = form == 1 ? {r[7:4], a[3:0]} : {r[7:5], a[4:0]};
        req = '{1'b1, wr, 1'b0, mmd_pkg::mmd_form_t'(form), form == 0 ? a[13:0] : r[21:8], op, d};
        e = a == 14 ? int'(m_idx) : a;
        if (e >= 'hc0 && e <= 'hff) e = {m_pg, e[5:0]};
        t = tgt(e);
        exp = t == 2 ? m_idx : t == 4 ? m_pg : e[7:0] ^ {2'h0, e[13:8]} ^ 8'(t * 17);
        #1;
        chk(ram_req.valid, t == 1);
        chk(pa_req.valid, t == 3);
        chk(pb_req.valid, t == 5);
        chk(nvm_req.valid, t == 6);
        case (t)
            1: chk(ram_req.addr, 16'(e));
            3: chk(pa_req.addr, 16'(e));
            5: chk(pb_req.addr, 16'(e));
            6: chk(nvm_req.addr, 16'(e));
            default: ;
        endcase
        if (t == 1 && wr) chk(ram_req.wdata, d);
        sel = t == 3 ? pa_req : t == 5 ? pb_req : t == 6 ? nvm_req : ram_req;
        if (t inside {1, 3, 5, 6}) chk(sel.write, wr);
        if (wr && (t inside {3, 5, 6})) chk(sel.wdata, d);
        if (wr && t == 2) m_idx = d;
        if (wr && t == 4) m_pg = d;
        @(negedge clk);
        chk(ack, t != 0);
        chk(rreq, t == 0);
        if (!wr && t != 0) chk(rdata, exp);
        chk(idx, m_idx);
        chk(pg, m_pg);
    endtask

    initial begin
        void'($urandom(69));
        m_idx = 8'h00;
        m_pg = 8'h00;
        repeat (20) @(negedge clk);
        rst = 1'b0;
        chk(idx, 8'h00);
        foreach (tab[i]) acc(tab[i] >> 28, (tab[i] >> 8) % 16384, tab[i][24], tab[i][7:0]);
        $display("test map walk done");
        repeat (400) begin
            r = $urandom;
            wd = r[7:0] == 8'h03 ? 8'h04 : r[7:0];
            acc(r[27:26] % 3, r[30] ? r[7:0] : r[21:8], r[24], wd);
        end
        req = '0;
        #1;
        chk(ram_req.valid, 1'b0);
        $display("test random done");
        @(negedge clk);
        acc(0, 15, 1'b1, 8'h9c);
        req = '0;
        rst = 1'b1;
        @(negedge clk);
        chk(idx, 8'h00);
        rst = 1'b0;
        m_idx = 8'h00;
        m_pg = 8'h00;
        acc(0, 14, 1'b0, 8'h00);
        req = '0;
        $display("test reset done");
        report_and_stop();
    end

    initial begin
        #800000;
        fails++;
        report_and_stop();
    end
endmodule
